// [core/drive_pkg.sv]
// Package for the drive command interpreter: register map,
// control and status bit positions, reset values, states, carriers.
// Assumes a 200 MHz APB clock and 32-bit APB data.
`default_nettype none

package drive_pkg;

    // Register byte addresses
    localparam logic [7:0] A_CTL = 8'h00;   // control_word
    localparam logic [7:0] A_SP = 8'h04;    // speed_setpoint_word
    localparam logic [7:0] A_STAT = 8'h08;  // status_word, read only
    localparam logic [7:0] A_ACT = 8'h0c;   // actual_frequency_word, read only
    localparam logic [7:0] A_SCALE = 8'h10; // setpoint_scale_param
    localparam logic [7:0] A_RATE = 8'h14;  // Ramp steps: normal low, fast high
    localparam logic [7:0] A_JOG = 8'h18;   // Jog speed, setpoint units
    localparam logic [7:0] A_CFG = 8'h1c;   // Bit 0: remote control

    // control_word bit positions
    localparam int C_RAMP = 0;   // ramp_stop_cmd, 0 ramps down
    localparam int C_COAST = 1;  // coast_stop_cmd, 0 switches off
    localparam int C_QUICK = 2;  // quick_stop_cmd, 0 fast ramp down
    localparam int C_RUN = 3;    // Run enable
    localparam int C_FAST = 4;   // Fast stop
    localparam int C_HOLD = 5;   // Ramp hold
    localparam int C_INH = 6;    // Ramp inhibit
    localparam int C_ACK = 7;    // Fault acknowledge
    localparam int C_JOGR = 8;   // Jog right
    localparam int C_JOGL = 9;   // Jog left
    localparam int C_VALID = 10; // Control valid
    localparam int C_ONR = 11;   // On right
    localparam int C_ONL = 12;   // On left

    // status_word bit positions
    localparam int S_INIT = 0;
    localparam int S_READY = 1;
    localparam int S_RUN = 2;
    localparam int S_FAULT = 3;
    localparam int S_COAST_NA = 4;
    localparam int S_QUICK_NA = 5;
    localparam int S_LOCK = 6;
    localparam int S_WARN = 7;
    localparam int S_ONE = 8;
    localparam int S_REMOTE = 9;
    localparam int S_ATSP = 10;
    localparam int S_RIGHT = 11;
    localparam int S_LEFT = 12;

    // Reset values and scaling
    localparam logic [15:0] SCALE_RST = 16'h09c4; // 50 Hz in 0.02 Hz steps
    localparam logic [31:0] RATE_RST = 32'h0100_0010;
    localparam logic [15:0] JOG_RST = 16'h0666;
    localparam logic CFG_RST = 1'b1;
    localparam logic [15:0] CTL_RST = 16'h0000;
    localparam logic [15:0] MAG_MAX = 16'h7fff;   // 200 percent
    localparam int SCALE_SHIFT = 14;              // 16384 is 100 percent

    // Power-up initialisation time
    localparam int CLK_NS = 5;
    localparam int INIT_NS = 1000;
    localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [5:0] {
        ST_INIT = 6'h01,
        ST_LOCK = 6'h02,
        ST_READY = 6'h04,
        ST_RUN = 6'h08,
        ST_QSTOP = 6'h10,
        ST_FAULT = 6'h20
    } st_e;

    // Power stage command carrier
    typedef struct packed {
        logic on;
        logic reverse;
        logic [15:0] freq;
    } drv_out_s;

    // APB answer carrier
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

endpackage

`default_nettype wire

// [core/drive_ctrl.sv]
// Drive command interpreter: control_word and speed_setpoint_word in,
// status_word and actual_frequency_word out, ramp and power stage command.
// Assumes an APB master on pclk; trip and warning arrive asynchronously.
//
// Operation
// - coast_stop_cmd low switches output off immediately
// - coast and quick stops and trips lock out until ramp_stop_cmd
// - quick_stop_cmd low fast ramps down
// - run enable low switches output off
// - fast stop low decelerates at fast rate
// - hold freezes ramp unless fast stop is low, inhibit ramps to zero
// - acknowledge rising between messages clears fault
// - jog bits jog in their direction
// - commands ignored while control valid low
// - on-left alone selects left, otherwise right; a reverse setpoint swaps them
// - status bit 8 one, 13-15 zero
// - status shows init, ready, running, fault
// - stop-available bits read zero when available
// - lockout status bit mirrors lockout state
// - warning bit follows warning condition
// - control source bit, one is remote
// - at-setpoint bit when output reaches setpoint
// - right and left bits show output direction
// - setpoint 16384 is 100, max 32767
// - setpoint upper half is reverse demand
// - frequency is setpoint times scale over 16384
// - actual word same scale, always positive
// - ramp_stop_cmd low ramps down
`default_nettype none

module drive_ctrl #(
    parameter int RAMP_DIV = 200,         // Clock cycles per ramp step
    parameter int INIT_CYCLES = drive_pkg::INIT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // Drive conditions, asynchronous
    input wire logic trip_in,
    input wire logic warn_in,
    // Power stage command
    output drive_pkg::drv_out_s drv_out
);

    // All state of the block
    typedef struct packed {
        drive_pkg::st_e st;
        drive_pkg::apb_rsp_s rsp;
        logic [15:0] ctl;      // Last control_word received
        logic [15:0] eff;      // Last valid control_word
        logic [15:0] sp;       // speed_setpoint_word
        logic [15:0] scale;    // setpoint_scale_param
        logic [31:0] rate;     // Ramp steps
        logic [15:0] jog;      // Jog speed
        logic remote;          // Control source
        logic ack_prev;        // Acknowledge bit of previous message
        logic ack_p;           // Acknowledge edge seen, one cycle
        logic trip1;
        logic trip2;
        logic warn1;
        logic warn2;
        logic [15:0] init_cnt;
        logic [15:0] div_cnt;
        logic [15:0] ramp;     // Output magnitude, setpoint units
        logic left;            // Output direction
        logic [15:0] stat;     // status_word
        drive_pkg::drv_out_s out;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    // Scratch values of the next-state process
    logic [15:0] e;
    logic [15:0] sp_mag;
    logic [15:0] target;
    logic [15:0] step;
    logic [16:0] sum;
    logic [31:0] prod;
    logic running;
    logic fast;
    logic hold;
    logic want_left;
    logic tick;
    logic trip;
    logic wr;
    logic msg;

    // Next state of the whole block
    always_comb begin
        s_nxt = s_r;
        e = s_r.eff;
        trip = s_r.trip2;
        target = 16'h0000;
        fast = 1'b0;
        hold = 1'b0;
        step = 16'h0000;
        sum = 17'h00000;

        // Two-stage synchronisers on the asynchronous conditions
        s_nxt.trip1 = trip_in;
        s_nxt.trip2 = s_r.trip1;
        s_nxt.warn1 = warn_in;
        s_nxt.warn2 = s_r.warn1;

        // APB: answer is prepared in setup, so access is one cycle
        s_nxt.rsp.pready = 1'b0;
        s_nxt.rsp.pslverr = 1'b0;
        if (psel && !penable) begin
            s_nxt.rsp.pready = 1'b1;
            s_nxt.rsp.prdata = 32'h0000_0000;
            unique case (paddr)
                drive_pkg::A_CTL: s_nxt.rsp.prdata = {16'h0000, s_r.ctl};
                drive_pkg::A_SP: s_nxt.rsp.prdata = {16'h0000, s_r.sp};
                drive_pkg::A_STAT: s_nxt.rsp.prdata = {16'h0000, s_r.stat};
                drive_pkg::A_ACT: s_nxt.rsp.prdata = {16'h0000, s_r.ramp};
                drive_pkg::A_SCALE: s_nxt.rsp.prdata = {16'h0000, s_r.scale};
                drive_pkg::A_RATE: s_nxt.rsp.prdata = s_r.rate;
                drive_pkg::A_JOG: s_nxt.rsp.prdata = {16'h0000, s_r.jog};
                drive_pkg::A_CFG: s_nxt.rsp.prdata = {31'h0000_0000, s_r.remote};
                // Unmapped: error answer, data zero
                default: s_nxt.rsp.pslverr = 1'b1;
            endcase
        end

        // Write takes effect at the access edge
        wr = psel && penable && pwrite && s_r.rsp.pready && !s_r.rsp.pslverr;
        msg = wr && (paddr == drive_pkg::A_CTL);
        if (wr) begin
            unique case (paddr)
                drive_pkg::A_SP: s_nxt.sp = pwdata[15:0];
                drive_pkg::A_SCALE: s_nxt.scale = pwdata[15:0];
                drive_pkg::A_RATE: s_nxt.rate = pwdata;
                drive_pkg::A_JOG: s_nxt.jog = pwdata[15:0];
                drive_pkg::A_CFG: s_nxt.remote = pwdata[0];
                // Status, actual frequency and control need no store here
                default: ;
            endcase
        end

        // A control_word write is one received message
        s_nxt.ack_p = 1'b0;
        if (msg) begin
            s_nxt.ctl = pwdata[15:0];
            s_nxt.ack_prev = pwdata[drive_pkg::C_ACK];
            // Invalid words and local control leave commands untouched
            if (pwdata[drive_pkg::C_VALID] && s_r.remote) begin
                s_nxt.eff = pwdata[15:0];
                s_nxt.ack_p = pwdata[drive_pkg::C_ACK] && !s_r.ack_prev;
            end
        end

        // Ramp step timebase
        tick = (s_r.div_cnt == 16'h0000);
        s_nxt.div_cnt = tick ? 16'(RAMP_DIV - 1) : s_r.div_cnt - 16'h0001;

        // Setpoint magnitude; upper half is two's complement reverse
        sp_mag = s_r.sp[15] ? 16'(-s_r.sp) : s_r.sp;
        if (sp_mag > drive_pkg::MAG_MAX) begin
            sp_mag = drive_pkg::MAG_MAX;
        end

        // Direction wanted: jog bits first, else on bits, with a reverse setpoint swapping the side
        if (e[drive_pkg::C_JOGR] || e[drive_pkg::C_JOGL]) begin
            want_left = e[drive_pkg::C_JOGL] && !e[drive_pkg::C_JOGR];
        end else begin
            want_left = (e[drive_pkg::C_ONL] && !e[drive_pkg::C_ONR]) ^ s_r.sp[15];
        end

        // Command state machine
        unique case (s_r.st)
            drive_pkg::ST_INIT: begin
                // Power-up initialisation, then locked out
                if (s_r.init_cnt == 16'h0000) begin
                    s_nxt.st = drive_pkg::ST_LOCK;
                end else begin
                    s_nxt.init_cnt = s_r.init_cnt - 16'h0001;
                end
            end
            drive_pkg::ST_LOCK: begin
                if (trip) begin
                    s_nxt.st = drive_pkg::ST_FAULT;
                end else if (!e[drive_pkg::C_RAMP] && e[drive_pkg::C_COAST] && e[drive_pkg::C_QUICK]) begin
                    s_nxt.st = drive_pkg::ST_READY;
                end
            end
            drive_pkg::ST_READY: begin
                if (trip) begin
                    s_nxt.st = drive_pkg::ST_FAULT;
                end else if (!e[drive_pkg::C_COAST] || !e[drive_pkg::C_QUICK]) begin
                    s_nxt.st = drive_pkg::ST_LOCK;
                end else if (e[drive_pkg::C_RUN] && (e[drive_pkg::C_RAMP] || e[drive_pkg::C_JOGR]
                             || e[drive_pkg::C_JOGL])) begin
                    s_nxt.st = drive_pkg::ST_RUN;
                end
            end
            drive_pkg::ST_RUN: begin
                if (trip) begin
                    s_nxt.st = drive_pkg::ST_FAULT;
                end else if (!e[drive_pkg::C_COAST]) begin
                    s_nxt.st = drive_pkg::ST_LOCK;
                end else if (!e[drive_pkg::C_QUICK]) begin
                    s_nxt.st = drive_pkg::ST_QSTOP;
                end else if (!e[drive_pkg::C_RUN]) begin
                    s_nxt.st = drive_pkg::ST_READY;
                end else begin
                    if (e[drive_pkg::C_JOGR] || e[drive_pkg::C_JOGL]) begin
                        target = s_r.jog;
                    end else if (e[drive_pkg::C_RAMP]) begin
                        target = sp_mag;
                    end else if (s_r.ramp == 16'h0000) begin
                        s_nxt.st = drive_pkg::ST_READY;
                    end
                    if (!e[drive_pkg::C_INH]) begin
                        target = 16'h0000;
                    end
                    // Reversal passes through zero first
                    if (want_left != s_r.left) begin
                        target = 16'h0000;
                    end
                    if (!e[drive_pkg::C_FAST]) begin
                        target = 16'h0000;
                        fast = 1'b1;
                    end
                    hold = !e[drive_pkg::C_HOLD] && !fast;
                end
            end
            drive_pkg::ST_QSTOP: begin
                fast = 1'b1;
                if (trip) begin
                    s_nxt.st = drive_pkg::ST_FAULT;
                end else if (!e[drive_pkg::C_COAST] || !e[drive_pkg::C_RUN]) begin
                    // Coast or run enable low cuts a quick stop short, output off now
                    s_nxt.st = drive_pkg::ST_LOCK;
                end else if (s_r.ramp == 16'h0000) begin
                    s_nxt.st = drive_pkg::ST_LOCK;
                end
            end
            drive_pkg::ST_FAULT: begin
                // Cleared only once the trip itself has gone
                if (s_r.ack_p && !trip) begin
                    s_nxt.st = drive_pkg::ST_LOCK;
                end
            end
        endcase

        // Output stays on only while running or quick stopping
        running = (s_nxt.st == drive_pkg::ST_RUN) || (s_nxt.st == drive_pkg::ST_QSTOP);

        // Ramp generator; leaving the run states drops output at once
        if (!running) begin
            s_nxt.ramp = 16'h0000;
        end else if (tick && !hold) begin
            step = fast ? s_r.rate[31:16] : s_r.rate[15:0];
            if (s_r.ramp < target) begin
                sum = {1'b0, s_r.ramp} + {1'b0, step};
                s_nxt.ramp = (sum > {1'b0, target}) ? target : sum[15:0];
            end else if (s_r.ramp > target) begin
                sum = {1'b0, s_r.ramp} - {1'b0, step};
                s_nxt.ramp = (sum[16] || sum[15:0] < target) ? target : sum[15:0];
            end
        end

        // Direction may change only at standstill
        if (s_nxt.ramp == 16'h0000) begin
            s_nxt.left = want_left;
        end

        // Frequency in 0.02 Hz steps
        prod = s_nxt.ramp * s_r.scale;
        s_nxt.out.freq = prod[drive_pkg::SCALE_SHIFT +: 16];
        s_nxt.out.on = running;
        s_nxt.out.reverse = s_nxt.left;

        // status_word
        s_nxt.stat = 16'h0000;
        s_nxt.stat[drive_pkg::S_ONE] = 1'b1;
        s_nxt.stat[drive_pkg::S_INIT] = (s_nxt.st != drive_pkg::ST_INIT);
        s_nxt.stat[drive_pkg::S_READY] = (s_nxt.st == drive_pkg::ST_READY);
        s_nxt.stat[drive_pkg::S_RUN] = running;
        s_nxt.stat[drive_pkg::S_FAULT] = (s_nxt.st == drive_pkg::ST_FAULT);
        // Both stop functions always exist here, so both read zero
        s_nxt.stat[drive_pkg::S_COAST_NA] = 1'b0;
        s_nxt.stat[drive_pkg::S_QUICK_NA] = 1'b0;
        s_nxt.stat[drive_pkg::S_LOCK] = (s_nxt.st == drive_pkg::ST_LOCK);
        s_nxt.stat[drive_pkg::S_WARN] = s_r.warn2;
        s_nxt.stat[drive_pkg::S_REMOTE] = s_nxt.remote;
        s_nxt.stat[drive_pkg::S_ATSP] = (s_nxt.ramp >= sp_mag);
        s_nxt.stat[drive_pkg::S_RIGHT] = running && !s_nxt.left;
        s_nxt.stat[drive_pkg::S_LEFT] = running && s_nxt.left;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.st <= drive_pkg::ST_INIT;
            s_r.rsp <= '0;
            s_r.ctl <= drive_pkg::CTL_RST;
            s_r.eff <= drive_pkg::CTL_RST;
            s_r.sp <= 16'h0000;
            s_r.scale <= drive_pkg::SCALE_RST;
            s_r.rate <= drive_pkg::RATE_RST;
            s_r.jog <= drive_pkg::JOG_RST;
            s_r.remote <= drive_pkg::CFG_RST;
            s_r.ack_prev <= 1'b0;
            s_r.ack_p <= 1'b0;
            s_r.trip1 <= 1'b0;
            s_r.trip2 <= 1'b0;
            s_r.warn1 <= 1'b0;
            s_r.warn2 <= 1'b0;
            s_r.init_cnt <= 16'(INIT_CYCLES - 1);
            s_r.div_cnt <= 16'h0000;
            s_r.ramp <= 16'h0000;
            s_r.left <= 1'b0;
            s_r.stat <= 16'h0100;
            s_r.out <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign pready = s_r.rsp.pready;
    assign pslverr = s_r.rsp.pslverr;
    assign prdata = s_r.rsp.prdata;
    assign drv_out = s_r.out;

endmodule

`default_nettype wire

// [verification/drive_ctrl_props.sv]
// Concurrent checks on the ports of the drive command interpreter.
// Assumes zero wait APB and a status word that settles a few cycles after a change.
`default_nettype none

module drive_ctrl_props #(
    parameter int RAMP_DIV = 200,
    parameter int INIT_CYCLES = 200
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Drive side
    input wire logic trip_in,
    input wire logic warn_in,
    input wire drive_pkg::drv_out_s drv_out
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic remote_q;       // Remote flag as last written
    logic [3:0] warn_age; // Cycles since warn_in moved, saturating
    logic [3:0] cfg_age;  // Cycles since a config write, saturating
    // Valid control write accepted while remote
    wire logic ctl_wr = psel && penable && pready && pwrite && paddr == drive_pkg::A_CTL
        && pwdata[drive_pkg::C_VALID] && remote_q;
    wire logic rd_st = pready && !pwrite && paddr == drive_pkg::A_STAT; // Status read answer

    // Ages let status checks wait past the synchroniser and status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_q <= drive_pkg::CFG_RST;
            warn_age <= 4'h0;
            cfg_age <= 4'h0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == drive_pkg::A_CFG) begin
                remote_q <= pwdata[0];
                cfg_age <= 4'h0;
            end else if (cfg_age != 4'h8) begin
                cfg_age <= cfg_age + 4'h1;
            end
            warn_age <= $changed(warn_in) ? 4'h0 : (warn_age == 4'h8 ? warn_age : warn_age + 4'h1);
        end
    end

    zero_wait_a: assert property (psel && !penable |=> pready) else $error("No answer after setup");
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h1c |=> pslverr && prdata == 32'h0)
        else $error("Unmapped access not refused");
    coast_off_a: assert property (ctl_wr && !pwdata[drive_pkg::C_COAST] |-> ##3 !drv_out.on)
        else $error("Output on after coast stop");
    run_off_a: assert property (ctl_wr && !pwdata[drive_pkg::C_RUN] |-> ##3 !drv_out.on)
        else $error("Output on after run enable low");
    stat_fixed_a: assert property (rd_st |-> prdata[8] && prdata[31:13] == 19'h0)
        else $error("Fixed status bits wrong");
    stop_avail_a: assert property (rd_st |-> prdata[5:4] == 2'b00)
        else $error("Stop available bits wrong");
    lock_no_run_a: assert property (rd_st && prdata[drive_pkg::S_LOCK] |-> !drv_out.on)
        else $error("Running in lockout");
    act_range_a: assert property (pready && !pwrite && paddr == drive_pkg::A_ACT |-> prdata[31:15] == 17'h0)
        else $error("Actual frequency out of range");
    warn_bit_a: assert property (rd_st && warn_age == 4'h8 |-> prdata[drive_pkg::S_WARN] == warn_in)
        else $error("Warning bit wrong");
    remote_bit_a: assert property (rd_st && cfg_age == 4'h8 |-> prdata[drive_pkg::S_REMOTE] == remote_q)
        else $error("Control source bit wrong");
    dir_excl_a: assert property (rd_st |-> !(prdata[drive_pkg::S_RIGHT] && prdata[drive_pkg::S_LEFT]))
        else $error("Both direction bits set");

    cover property (rd_st && prdata[drive_pkg::S_LOCK]);
    cover property (rd_st && prdata[drive_pkg::S_LEFT]);
    cover property (pslverr);
endmodule

bind drive_ctrl drive_ctrl_props #(.RAMP_DIV(RAMP_DIV), .INIT_CYCLES(INIT_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .trip_in(trip_in), .warn_in(warn_in), .drv_out(drv_out));

`default_nettype wire

// [verification/apb_master_model.sv]
// Bus master model standing in front of the drive register bank.
// Assumes the slave raises pready; the bench watchdog ends any hang.
`default_nettype none

module apb_master_model (
    // Clock
    input wire logic pclk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // Answer
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer; released lines show the inverse so stale data never looks valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= ~w;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

`default_nettype wire

// [verification/drive_ctrl_test.sv]
// Self-checking bench for the drive command interpreter.
// Assumes the bus master model and the bound checker are compiled alongside.
`default_nettype none

module drive_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic trip_in = 1'b0;
    logic warn_in = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    drive_pkg::drv_out_s drv_out;
    int n_errors = 0;
    int n_checks = 0;
    int seed = 32'h8fda8f58;
    logic [15:0] m; // Random setpoint magnitude
    // Writable registers and their reset values
    logic [7:0] ra [6] = '{drive_pkg::A_CTL, drive_pkg::A_SP, drive_pkg::A_SCALE, drive_pkg::A_RATE,
        drive_pkg::A_JOG, drive_pkg::A_CFG};
    logic [31:0] rv [6] = '{32'(drive_pkg::CTL_RST), 32'h0, 32'(drive_pkg::SCALE_RST), drive_pkg::RATE_RST,
        32'(drive_pkg::JOG_RST), 32'(drive_pkg::CFG_RST)};

    always #2.5 pclk = ~pclk;

    // Short ramp and init counts keep the run brief
    drive_ctrl #(.RAMP_DIV(4), .INIT_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .trip_in(trip_in), .warn_in(warn_in), .drv_out(drv_out));
    apb_master_model bus (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));

    task automatic final_report;
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a);
        bus.xfer(1'b0, a, 32'h0, q, e);
    endtask

    // Read status until a bit takes the wanted value; bounded so a stuck bit reports
    task automatic pollb(input int b, input logic v, input string nm);
        rd(drive_pkg::A_STAT);
        for (int i = 0; i < 3000 && q[b] !== v; i++) rd(drive_pkg::A_STAT);
        chk(nm, 32'(v), 32'(q[b]));
    endtask

    // Expected output frequency: ramp magnitude times scale over 16384
    function automatic logic [15:0] freq(input logic [15:0] r);
        return 16'((32'(r) * 32'(drive_pkg::SCALE_RST)) >> 14);
    endfunction

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) begin
            rd(ra[i]);
            chk("reset value", rv[i], q);
        end
        rd(8'h20);
        chk("unmapped error", 32'h1, 32'(e));
        wr(drive_pkg::A_STAT, 32'hffff); // Read-only place must ignore this
        pollb(drive_pkg::S_INIT, 1'b1, "init done");
        chk("power-up lockout", 32'h1, 32'(q[drive_pkg::S_LOCK]));
        wr(drive_pkg::A_CTL, 32'h0406);
        pollb(drive_pkg::S_LOCK, 1'b0, "lockout left");
        chk("ready", 32'h1, 32'(q[drive_pkg::S_READY]));
        m = 16'h0100 + 16'($random(seed) & 32'h0eff);
        wr(drive_pkg::A_SP, 32'(m));
        wr(drive_pkg::A_CTL, 32'h0c7f);
        pollb(drive_pkg::S_ATSP, 1'b1, "at setpoint");
        chk("right", 32'h1, 32'(q[drive_pkg::S_RIGHT]));
        #1 chk("frequency", 32'(freq(m)), 32'(drv_out.freq));
        rd(drive_pkg::A_ACT);
        chk("actual", 32'(m), q);
        wr(drive_pkg::A_SP, 32'(16'h0 - m));
        pollb(drive_pkg::S_LEFT, 1'b1, "left");
        pollb(drive_pkg::S_ATSP, 1'b1, "reverse at setpoint");
        rd(drive_pkg::A_ACT);
        chk("actual reverse", 32'(m), q);
        wr(drive_pkg::A_CTL, 32'h0000); // Invalid word: output must stay on
        repeat (8) @(posedge pclk);
        chk("invalid ignored", 32'h1, 32'(drv_out.on));
        wr(drive_pkg::A_CTL, 32'h0c3f);
        rd(drive_pkg::A_ACT);
        for (int i = 0; i < 3000 && q !== 32'h0; i++) rd(drive_pkg::A_ACT);
        chk("inhibit to zero", 32'h0, q);
        wr(drive_pkg::A_CTL, 32'h0c5f); // Hold at zero though setpoint is not zero
        repeat (40) @(posedge pclk);
        rd(drive_pkg::A_ACT);
        chk("hold", 32'h0, q);
        wr(drive_pkg::A_CTL, 32'h0c7f);
        pollb(drive_pkg::S_ATSP, 1'b1, "hold released");
        wr(drive_pkg::A_CTL, 32'h0c7d);
        repeat (3) @(posedge pclk);
        chk("coast off", 32'h0, 32'(drv_out.on));
        pollb(drive_pkg::S_LOCK, 1'b1, "coast lockout");
        wr(drive_pkg::A_CTL, 32'h0406);
        wr(drive_pkg::A_CTL, 32'h0c7f);
        pollb(drive_pkg::S_RUN, 1'b1, "run again");
        wr(drive_pkg::A_CTL, 32'h0c77);
        repeat (3) @(posedge pclk);
        chk("run enable off", 32'h0, 32'(drv_out.on));
        wr(drive_pkg::A_CTL, 32'h0c7f);
        pollb(drive_pkg::S_ATSP, 1'b1, "before fast stop");
        wr(drive_pkg::A_CTL, 32'h0c6f);
        pollb(drive_pkg::S_ATSP, 1'b0, "fast stop");
        chk("fast stop on", 32'h1, 32'(drv_out.on));
        wr(drive_pkg::A_CTL, 32'h0c7e);
        pollb(drive_pkg::S_READY, 1'b1, "ramp stop");
        wr(drive_pkg::A_CTL, 32'h0c7f);
        pollb(drive_pkg::S_ATSP, 1'b1, "before quick stop");
        wr(drive_pkg::A_CTL, 32'h0c7b);
        pollb(drive_pkg::S_LOCK, 1'b1, "quick stop lockout");
        rd(drive_pkg::A_ACT);
        chk("quick stop zero", 32'h0, q);
        wr(drive_pkg::A_CTL, 32'h0406);
        trip_in <= 1'b1;
        pollb(drive_pkg::S_FAULT, 1'b1, "trip fault");
        trip_in <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(drive_pkg::A_CTL, 32'h0486);
        pollb(drive_pkg::S_FAULT, 1'b0, "ack clears fault");
        chk("trip lockout", 32'h1, 32'(q[drive_pkg::S_LOCK]));
        wr(drive_pkg::A_CTL, 32'h0406);
        wr(drive_pkg::A_CTL, 32'h060e);
        pollb(drive_pkg::S_LEFT, 1'b1, "jog left");
        chk("jog on", 32'h1, 32'(drv_out.on));
        warn_in <= 1'b1;
        repeat (10) @(posedge pclk);
        rd(drive_pkg::A_STAT);
        chk("warning", 32'h1, 32'(q[drive_pkg::S_WARN]));
        warn_in <= 1'b0;
        wr(drive_pkg::A_CFG, 32'h0);
        repeat (10) @(posedge pclk);
        rd(drive_pkg::A_STAT);
        chk("local control", 32'h0, 32'(q[drive_pkg::S_REMOTE]));
        final_report;
    end

    // Watchdog well beyond the expected run
    initial begin
        repeat (100000) @(posedge pclk);
        n_errors++;
        final_report;
    end
endmodule

`default_nettype wire
